// ==== design/disk_err_defines.vh ====
// Constants of the disk error status reporter: register map, field
// positions, reset values, status codes, command codes and timing.
// Assumes a 125 MHz aclk and a 32-bit AXI4-Lite register port.
`ifndef DISK_ERR_DEFINES_VH
`define DISK_ERR_DEFINES_VH

// Register word indices (address bits 4:2)
`define RA_PTR 3'd0
`define RA_LEN 3'd1
`define RA_CTRL 3'd2
`define RA_WIN 3'd3
`define RA_STAT 3'd4
`define RA_LAST 3'd5

// Reset values
`define RV_PTR 32'h0000_0000
`define RV_LEN 16'h0000
`define RV_CTRL 2'h0
`define RV_WIN 24'h0000_00

// Control bits
`define CTRL_EN 0
`define CTRL_REWIND 1

// Window configuration fields
`define WIN_POST_LO 0
`define WIN_PAD_LO 8
`define WIN_PRE_LO 16

// Status register fields
`define ST_OFF_LO 0
`define ST_CNT_LO 16
`define ST_FULL 24
`define ST_OVR 25
`define ST_BUSY 26

// Command option bits
`define OPT_NEXT_NF 0
`define OPT_NEXT_F 1
`define OPT_TRK_VERIFY 2
`define OPT_ARB_SECT 3

// Result block stride in bytes (10 used, padded to three words)
`define BLK_BYTES 16'h000C

// Status codes
`define C_INDEX 8'h00
`define C_NO_ID 8'h01
`define C_SEEK 8'h02
`define C_ECC 8'h03
`define C_SYNC 8'h04
`define C_RELOC 8'h05
`define C_NO_VEC 8'h06
`define C_RNF_ID 8'h07
`define C_FSEEK 8'h08
`define C_RNF 8'h09
`define C_RETRY 8'h0A
`define C_NOVERIFY 8'h0B
`define C_NOT_REC 8'h17

// Command codes
`define CMD_READ 5'd0
`define CMD_WRITE 5'd1
`define CMD_VERIFY 5'd2
`define CMD_FORMAT 5'd3
`define CMD_RELOC 5'd4
`define CMD_LDPAR 5'd5
`define CMD_DPPAR 5'd6
`define CMD_RDPHYS 5'd7
`define CMD_RDID 5'd8
`define CMD_LDBUF 5'd9
`define CMD_DPBUF 5'd10
`define CMD_LDSYN 5'd11
`define CMD_DPSYN 5'd12
`define CMD_CORR 5'd13
`define CMD_SEEK 5'd14
`define CMD_RESTORE 5'd15
`define CMD_CHAN 5'd16

// Revolutions: three index pulses end a sector search
`define IDX_LIMIT 2'd2

// Disk byte time and the cycles derived from it at the aclk rate
`define BYTE_NS 64
`define CLK_NS 8
`define BYTE_CYC ((`BYTE_NS + `CLK_NS - 1) / `CLK_NS)

// AXI responses
`define RESP_OK 2'b00
`define RESP_SLVERR 2'b10

`endif

// ==== design/err_classify.v ====
// Status code classifier: which codes a command may produce, and
// whether a code ends the command. Purely combinational.
// Assumes code and command are stable while a result is being decided.
`timescale 1ns/100ps
`include "disk_err_defines.vh"

module err_classify (
  input wire [7:0] code,
  input wire [4:0] cmd,
  input wire auto_vector,
  output reg allowed,
  output reg fatal
);

  reg [31:0] mask;
  wire rw = (cmd == `CMD_READ) || (cmd == `CMD_WRITE) || (cmd == `CMD_VERIFY);

  // Bit n of the mask permits status code n
  always @* begin
    case (cmd)
      `CMD_READ: mask = 32'h4DFE_F7FF;
      `CMD_WRITE: mask = 32'h4D7E_B3E7;
      `CMD_VERIFY: mask = 32'h4DFE_FFF3;
      `CMD_FORMAT: mask = 32'h441E_3003;
      `CMD_RELOC: mask = 32'h441E_0003;
      `CMD_LDPAR, `CMD_DPPAR: mask = 32'h0000_1000;
      `CMD_RDPHYS: mask = 32'h449E_101F;
      `CMD_RDID: mask = 32'h4E1E_1034;
      `CMD_LDBUF, `CMD_DPBUF: mask = 32'h0020_1000;
      `CMD_LDSYN, `CMD_DPSYN: mask = 32'h0001_1000;
      `CMD_CORR: mask = 32'h2001_1010;
      `CMD_SEEK: mask = 32'h4C1E_000C;
      `CMD_RESTORE: mask = 32'h4C16_000C;
      `CMD_CHAN: mask = 32'h0400_0000;
      default: mask = 32'h0000_0000;
    endcase
    allowed = (code[7:5] == 3'b000) && mask[code[4:0]];
  end

  // Recovered data and a first seek mismatch during transfers keep going
  always @* begin
    case (code)
      `C_ECC, `C_RETRY, `C_NOVERIFY, `C_NOT_REC: fatal = 1'b0;
      `C_SEEK: fatal = !rw;
      `C_RELOC: fatal = !auto_vector;
      default: fatal = 1'b1;
    endcase
  end

endmodule // err_classify

// ==== design/disk_error_status_reporter.v ====
// Error reporter of a disk controller: detects error conditions, writes
// result blocks into a host memory area and steers command termination.
// Assumes the disk sequencer drives its strobes on aclk; index and
// address-mark pins are asynchronous; memory port holds mem_ready protocol.
//
// Functional notes
// - Result area: 32-bit pointer, 16-bit length
// - Error at command end appends result block; here each block is written as soon as its error is detected
// - Each block carries parameter block ID
// - Fatal ends command, non-fatal continues it
// - Next command only if options permit
// - Status code sits in byte 3
// - Format index too early gives 00
// - Index during header/data access gives 00
// - No valid header on track gives 01
// - Header track/head mismatch gives 02
// - Mismatch retried once, then fatal 08
// - ECC recovery gives 03 with retries
// - Data mark window timeout gives 04
// - Read-ID arbitrary sector missing gives 04
// - Relocated track gives 05, auto-vector moves
// - No vector recovered gives 06, no move
// - Three index pulses: 07 or 09
// - Recovery by rereads gives 0A with count
// - Verify compare failure gives 0B
// - Only permitted codes per command
`timescale 1ns/100ps
`include "disk_err_defines.vh"

module disk_error_status_reporter (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire [4:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [4:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  input wire index_pin,
  input wire address_mark_found,
  input wire cmd_start,
  input wire [4:0] cmd_code,
  input wire [15:0] cmd_id,
  input wire [3:0] cmd_opt,
  input wire cmd_end,
  input wire auto_vector,
  input wire fmt_busy,
  input wire hdr_busy,
  input wire data_busy,
  input wire sect_search,
  input wire sector_over,
  input wire hdr_ok,
  input wire hdr_bad,
  input wire [15:0] hdr_track,
  input wire [7:0] hdr_head,
  input wire [15:0] want_track,
  input wire [7:0] want_head,
  input wire [7:0] want_sector,
  input wire win_start,
  input wire id_notfound,
  input wire reloc_found,
  input wire [15:0] reloc_track,
  input wire [7:0] reloc_head,
  input wire vec_fail,
  input wire rec_ecc,
  input wire rec_retry,
  input wire [7:0] retry_cnt,
  input wire cmp_fail,
  input wire ext_valid,
  input wire [7:0] ext_code,
  output reg mem_valid,
  output reg [31:0] mem_addr,
  output reg [31:0] mem_data,
  output reg [3:0] mem_strb,
  input wire mem_ready,
  output reg cmd_abort,
  output reg restore_req,
  output reg vector_req,
  output reg next_valid,
  output reg next_ok
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  reg idx_s1_q, idx_s2_q, idx_s3_q, amf_s1_q, amf_s2_q;
  wire idx_p = idx_s2_q && !idx_s3_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      idx_s1_q <= 1'b0;
      idx_s2_q <= 1'b0;
      idx_s3_q <= 1'b0;
      amf_s1_q <= 1'b0;
      amf_s2_q <= 1'b0;
    end else if (ce) begin
      idx_s1_q <= index_pin;
      idx_s2_q <= idx_s1_q;
      idx_s3_q <= idx_s2_q;
      amf_s1_q <= address_mark_found;
      amf_s2_q <= amf_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register port

  reg [31:0] ptr_q;
  reg [15:0] len_q;
  reg [1:0] ctrl_q;
  reg [23:0] win_q;
  reg [15:0] off_q;
  reg [7:0] cnt_q;
  reg full_q, ovr_q;
  reg [1:0] ws_q;
  reg [31:0] w0_q;
  wire busy = (ws_q != 2'd0);
  wire [31:0] wmask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
  wire wr_fire = awready && awvalid && wvalid;
  wire [2:0] wsel = awaddr[4:2];
  wire wmap = (wsel <= `RA_LAST);
  wire rewind = wr_fire && (wsel == `RA_CTRL) && wstrb[0] && wdata[`CTRL_REWIND];
  reg [31:0] rmux;

  always @* begin
    case (araddr[4:2])
      `RA_PTR: rmux = ptr_q;
      `RA_LEN: rmux = {16'h0000, len_q};
      `RA_CTRL: rmux = {30'h0000_0000, ctrl_q};
      `RA_WIN: rmux = {8'h00, win_q};
      `RA_STAT: rmux = {5'h00, busy, ovr_q, full_q, cnt_q, off_q};
      `RA_LAST: rmux = w0_q;
      default: rmux = 32'h0000_0000;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OK;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= `RESP_OK;
      rdata <= 32'h0000_0000;
      ptr_q <= `RV_PTR;
      len_q <= `RV_LEN;
      ctrl_q <= `RV_CTRL;
      win_q <= `RV_WIN;
    end else if (ce) begin
      // Both channels are taken in the same cycle, whichever came first
      if (!awready && awvalid && wvalid && !bvalid) begin
        awready <= 1'b1;
        wready <= 1'b1;
      end else begin
        awready <= 1'b0;
        wready <= 1'b0;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp <= wmap && (wsel != `RA_STAT) && (wsel != `RA_LAST) ? `RESP_OK : `RESP_SLVERR;
        case (wsel)
          `RA_PTR: ptr_q <= (ptr_q & ~wmask) | (wdata & wmask);
          `RA_LEN: len_q <= (len_q & ~wmask[15:0]) | (wdata[15:0] & wmask[15:0]);
          `RA_CTRL: if (wstrb[0]) ctrl_q <= {1'b0, wdata[`CTRL_EN]};
          `RA_WIN: win_q <= (win_q & ~wmask[23:0]) | (wdata[23:0] & wmask[23:0]);
          default: ;
        endcase
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      arready <= !arready && arvalid && !rvalid;
      if (arready && arvalid) begin
        rvalid <= 1'b1;
        rdata <= rmux;
        rresp <= (araddr[4:2] <= `RA_LAST) ? `RESP_OK : `RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Condition detectors

  reg [4:0] cmd_q;
  reg [15:0] id_q;
  reg [3:0] opt_q;
  reg err_q, fat_q, retried_q;
  reg [1:0] idx_cnt_q;
  reg amf_seen_q, bad_seen_q;
  reg [15:0] tmo_q;
  wire rw_cmd = (cmd_q == `CMD_READ) || (cmd_q == `CMD_WRITE) || (cmd_q == `CMD_VERIFY);
  wire seek_cmd = (cmd_q == `CMD_SEEK) || (cmd_q == `CMD_RESTORE);
  wire mism = (hdr_track != want_track) || (hdr_head != want_head);
  wire [9:0] win_bytes = {2'b00, win_q[`WIN_POST_LO +: 8]} + {2'b00, win_q[`WIN_PAD_LO +: 8]}
                       + {2'b00, win_q[`WIN_PRE_LO +: 8]};
  // Full product kept, then cut on purpose: the window never needs more than 16 bits
  wire [31:0] win_prod = {22'h00_0000, win_bytes} * `BYTE_CYC;
  wire [15:0] win_cyc = win_prod[15:0];

  reg ev_v;
  reg [7:0] ev_c;
  reg [7:0] ev_b2;
  reg [47:0] ev_f;

  // One condition per cycle; drive faults first, then search outcomes
  always @* begin
    ev_v = 1'b0;
    ev_c = 8'h00;
    ev_b2 = 8'h00;
    ev_f = {8'h00, want_sector, 8'h00, want_head, want_track};
    if (idx_p && (fmt_busy || hdr_busy || data_busy)) begin
      ev_v = 1'b1;
      ev_c = `C_INDEX;
    end else if (sector_over) begin
      ev_v = 1'b1;
      ev_c = `C_INDEX;
    end else if (idx_p && sect_search && idx_cnt_q == `IDX_LIMIT) begin
      ev_v = 1'b1;
      if (!amf_seen_q)
        ev_c = `C_NO_ID;
      else
        ev_c = bad_seen_q ? `C_RNF_ID : `C_RNF;
    end else if (hdr_ok && mism && !(seek_cmd && !opt_q[`OPT_TRK_VERIFY])) begin
      ev_v = 1'b1;
      ev_c = (rw_cmd && retried_q) ? `C_FSEEK : `C_SEEK;
      ev_f = {want_head, hdr_head, want_track, hdr_track};
    end else if (tmo_q == 16'h0001 && !amf_s2_q) begin
      ev_v = 1'b1;
      ev_c = `C_SYNC;
    end else if (id_notfound && cmd_q == `CMD_RDID && opt_q[`OPT_ARB_SECT]) begin
      ev_v = 1'b1;
      ev_c = `C_SYNC;
    end else if (reloc_found) begin
      ev_v = 1'b1;
      ev_c = `C_RELOC;
      ev_f = {reloc_head, hdr_head, reloc_track, hdr_track};
    end else if (vec_fail) begin
      ev_v = 1'b1;
      ev_c = `C_NO_VEC;
    end else if (rec_ecc) begin
      ev_v = 1'b1;
      ev_c = `C_ECC;
      ev_b2 = retry_cnt;
    end else if (rec_retry) begin
      ev_v = 1'b1;
      ev_c = `C_RETRY;
      ev_b2 = retry_cnt;
    end else if (cmp_fail && cmd_q == `CMD_VERIFY) begin
      ev_v = 1'b1;
      ev_c = `C_NOVERIFY;
    end else if (ext_valid) begin
      ev_v = 1'b1;
      ev_c = ext_code;
    end
  end

  wire allowed, fatal;

  err_classify u_classify (
    .code(ev_c),
    .cmd(cmd_q),
    .auto_vector(auto_vector),
    .allowed(allowed),
    .fatal(fatal)
  );

  wire ev_ok = ev_v && allowed;
  wire [16:0] end_off = {1'b0, off_q} + {1'b0, `BLK_BYTES};
  wire room = (end_off <= {1'b0, len_q});
  wire take = ev_ok && ctrl_q[`CTRL_EN] && !busy && room;

  ////////////////////////////////////////////////////////////////////////
  // Command tracking, search counters and block writer

  reg [31:0] w1_q, w2_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cmd_q <= 5'd0;
      id_q <= 16'h0000;
      opt_q <= 4'h0;
      err_q <= 1'b0;
      fat_q <= 1'b0;
      retried_q <= 1'b0;
      idx_cnt_q <= 2'd0;
      amf_seen_q <= 1'b0;
      bad_seen_q <= 1'b0;
      tmo_q <= 16'h0000;
      cmd_abort <= 1'b0;
      restore_req <= 1'b0;
      vector_req <= 1'b0;
      next_valid <= 1'b0;
      next_ok <= 1'b0;
      ws_q <= 2'd0;
      w0_q <= 32'h0000_0000;
      w1_q <= 32'h0000_0000;
      w2_q <= 32'h0000_0000;
      off_q <= 16'h0000;
      cnt_q <= 8'h00;
      full_q <= 1'b0;
      ovr_q <= 1'b0;
      mem_valid <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_data <= 32'h0000_0000;
      mem_strb <= 4'h0;
    end else if (ce) begin
      if (cmd_start) begin
        cmd_q <= cmd_code;
        id_q <= cmd_id;
        opt_q <= cmd_opt;
        err_q <= 1'b0;
        fat_q <= 1'b0;
        retried_q <= 1'b0;
      end else if (ev_ok) begin
        err_q <= 1'b1;
        fat_q <= fat_q || fatal;
        if (ev_c == `C_SEEK && rw_cmd)
          retried_q <= 1'b1;
      end
      cmd_abort <= ev_ok && fatal;
      restore_req <= ev_ok && ev_c == `C_SEEK && rw_cmd;
      vector_req <= ev_ok && ev_c == `C_RELOC && auto_vector;
      // Options only gate moving on when something went wrong
      next_valid <= cmd_end;
      if (cmd_end)
        next_ok <= !err_q || (fat_q ? opt_q[`OPT_NEXT_F] : opt_q[`OPT_NEXT_NF]);
      // Search counters live only while the sequencer is hunting a sector
      if (!sect_search) begin
        idx_cnt_q <= 2'd0;
        amf_seen_q <= 1'b0;
        bad_seen_q <= 1'b0;
      end else begin
        if (idx_p && idx_cnt_q != `IDX_LIMIT)
          idx_cnt_q <= idx_cnt_q + 2'd1;
        if (amf_s2_q)
          amf_seen_q <= 1'b1;
        if (hdr_bad)
          bad_seen_q <= 1'b1;
      end
      if (win_start)
        tmo_q <= (win_cyc == 16'h0000) ? 16'h0001 : win_cyc;
      else if (amf_s2_q)
        tmo_q <= 16'h0000;
      else if (tmo_q != 16'h0000)
        tmo_q <= tmo_q - 16'h0001;
      // Set beats the rewind that clears it
      if (ev_ok && ctrl_q[`CTRL_EN] && busy)
        ovr_q <= 1'b1;
      else if (rewind)
        ovr_q <= 1'b0;
      if (ev_ok && ctrl_q[`CTRL_EN] && !busy && !room)
        full_q <= 1'b1;
      else if (rewind)
        full_q <= 1'b0;
      if (take) begin
        w0_q <= {ev_c, ev_b2, id_q};
        w1_q <= ev_f[31:0];
        w2_q <= {16'h0000, ev_f[47:32]};
        ws_q <= 2'd1;
        mem_valid <= 1'b1;
        mem_addr <= ptr_q + {16'h0000, off_q};
        mem_data <= {ev_c, ev_b2, id_q};
        mem_strb <= 4'hF;
      end else if (mem_valid && mem_ready) begin
        case (ws_q)
          2'd1: begin
            ws_q <= 2'd2;
            mem_addr <= mem_addr + 32'h0000_0004;
            mem_data <= w1_q;
          end
          2'd2: begin
            ws_q <= 2'd3;
            mem_addr <= mem_addr + 32'h0000_0004;
            mem_data <= w2_q;
            mem_strb <= 4'h3;
          end
          default: begin
            ws_q <= 2'd0;
            mem_valid <= 1'b0;
            mem_strb <= 4'h0;
            off_q <= end_off[15:0];
            cnt_q <= cnt_q + 8'h01;
          end
        endcase
      end else if (rewind && !busy) begin
        off_q <= 16'h0000;
        cnt_q <= 8'h00;
      end
    end
  end

endmodule // disk_error_status_reporter

// ==== sim/err_report_monitor.sv ====
// Checker for the disk error status reporter, bound to its top module.
// Assumes one clock domain, aclk, with synchronous active-low aresetn.
`timescale 1ns/100ps
module err_report_monitor (
  input wire aclk,
  input wire aresetn,
  input wire awvalid,
  input wire wvalid,
  input wire awready,
  input wire wready,
  input wire [1:0] bresp,
  input wire bvalid,
  input wire arready,
  input wire rvalid,
  input wire rec_ecc,
  input wire cmd_end,
  input wire cmd_abort,
  input wire next_valid,
  input wire next_ok,
  input wire mem_valid,
  input wire mem_ready,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_data,
  input wire [3:0] mem_strb
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  a_write_taken: assert property (
    awvalid && wvalid && !bvalid && !awready |=> awready && wready)
    else $error("write request not taken");
  a_write_answer: assert property (
    awready && wready |=> bvalid)
    else $error("write response missing");
  a_read_answer: assert property (
    arready |=> rvalid)
    else $error("read data missing");
  a_next_follows_end: assert property (
    cmd_end |=> next_valid)
    else $error("no next decision after command end");
  a_next_has_cause: assert property (
    next_valid |-> $past(cmd_end))
    else $error("next decision without command end");
  a_ecc_not_fatal: assert property (
    rec_ecc |=> !cmd_abort)
    else $error("recovered data ended the command");
  a_words_consecutive: assert property (
    mem_valid && mem_ready && mem_strb == 4'hF |=>
      mem_valid && mem_addr == $past(mem_addr) + 32'h0000_0004)
    else $error("block word not at next address");
  a_tail_ends_block: assert property (
    mem_valid && mem_ready && mem_strb == 4'h3 |=> !mem_valid)
    else $error("block longer than three words");
  a_payload_held: assert property (
    mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr) && $stable(mem_data))
    else $error("memory write dropped while stalled");
  a_block_aligned: assert property (
    $rose(mem_valid) |-> mem_strb == 4'hF && mem_addr[1:0] == 2'b00)
    else $error("block does not open on a full word");
  c_block_done: cover property (mem_valid && mem_ready && mem_strb == 4'h3);
  c_abort: cover property (cmd_abort);
  c_next_refused: cover property (next_valid && !next_ok);
  c_slverr: cover property (bvalid && bresp == 2'b10);
endmodule // err_report_monitor

bind disk_error_status_reporter err_report_monitor monitor (.*);

// ==== sim/host_mem_model.sv ====
// Host memory model: accepts result-block words and keeps the address and first two words of the last block.
// Assumes the writer sends blocks as three words, first word first.
`timescale 1ns/100ps
module host_mem_model (
  input wire aclk,
  input wire aresetn,
  input wire stall,
  input wire mem_valid,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_data,
  input wire [3:0] mem_strb,
  output logic mem_ready,
  output logic [31:0] blk_addr,
  output logic [31:0] blk_w0,
  output logic [31:0] blk_w1,
  output int nblk
);
  int k;
  // Slow mode accepts on alternate cycles, so the writer must hold its word
  always @(posedge aclk) begin
    if (!aresetn) begin
      mem_ready <= 1'b0;
      k <= 0;
      nblk <= 0;
    end else begin
      mem_ready <= stall ? ~mem_ready : 1'b1;
      if (mem_valid && mem_ready) begin
        if (k == 0) begin
          blk_addr <= mem_addr;
          blk_w0 <= mem_data;
        end
        if (k == 1) blk_w1 <= mem_data;
        if (k == 2) nblk <= nblk + 1;
        k <= (k == 2) ? 0 : k + 1;
      end
    end
  end
endmodule // host_mem_model

// ==== sim/disk_error_status_reporter_bench.sv ====
// Bench of the disk error status reporter: registers over AXI4-Lite,
// then error events judged from the result blocks in host memory.
// Assumes host_mem_model and the bound monitor are compiled with it.
`timescale 1ns/100ps
`include "disk_err_defines.vh"
module disk_error_status_reporter_bench;
  localparam int RETRY = 0, ECC = 1, CMP = 2, VEC = 3, CEND = 4, CSTART = 5, HOK = 6;
  localparam int HBAD = 7, RELOC = 8, WIN = 11;
  localparam logic [4:0] A_PTR = {`RA_PTR, 2'b00}, A_LEN = {`RA_LEN, 2'b00};
  localparam logic [4:0] A_CTRL = {`RA_CTRL, 2'b00}, A_STAT = {`RA_STAT, 2'b00};
  logic aclk, aresetn = 1'b0, ce = 1'b1, stall = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [4:0] awaddr = '0, araddr = '0, cmd_code = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hF, cmd_opt = '0;
  logic index_pin = 1'b0, address_mark_found = 1'b0, auto_vector = 1'b0, sect_search = 1'b0;
  logic fmt_busy = 1'b0, hdr_busy = 1'b0, data_busy = 1'b0;
  logic [15:0] cmd_id = '0, hdr_track = '0, want_track = '0, reloc_track = '0;
  logic [7:0] hdr_head = '0, want_head = '0, want_sector = '0, reloc_head = '0;
  logic [7:0] retry_cnt = '0, ext_code = '0;
  logic [12:0] p = '0;
  wire awready, wready, bvalid, arready, rvalid, mem_valid, mem_ready;
  wire cmd_abort, restore_req, vector_req, next_valid, next_ok;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata, mem_addr, mem_data, blk_addr, blk_w0, blk_w1;
  wire [3:0] mem_strb;
  wire cmd_start, cmd_end, sector_over, hdr_ok, hdr_bad, win_start, id_notfound;
  wire reloc_found, vec_fail, rec_ecc, rec_retry, cmp_fail, ext_valid;
  int nblk, nb = 0, n_mismatch = 0, total_checks = 0;
  // Every event strobe comes from one vector so a pulse is one assignment
  assign {ext_valid, win_start, id_notfound, sector_over, reloc_found, hdr_bad, hdr_ok,
    cmd_start, cmd_end, vec_fail, cmp_fail, rec_ecc, rec_retry} = p;
  disk_error_status_reporter dut (.*);
  host_mem_model mdl (.*);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic hang();
    n_mismatch++;
    summarize();
  endtask
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 100 && bvalid !== 1'b1; i++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    if (i == 100) hang();
    bready <= 1'b0;
    chk("write response", 32'(er), 32'(bresp));
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er, input string w);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 100 && rvalid !== 1'b1; i++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    if (i == 100) hang();
    rready <= 1'b0;
    chk(w, e, rdata);
    chk("read response", 32'(er), 32'(rresp));
  endtask
  task automatic pulse(input int k);
    @(posedge aclk);
    p <= 13'h0001 << k;
    @(posedge aclk);
    p <= '0;
  endtask
  task automatic start(input logic [4:0] c, input logic [3:0] o, input logic [15:0] id);
    cmd_code <= c;
    cmd_opt <= o;
    cmd_id <= id;
    pulse(CSTART);
  endtask
  task automatic blk(input string w, input logic [31:0] w0, input logic [31:0] a);
    int i;
    nb++;
    for (i = 0; i < 200 && nblk != nb; i++) @(posedge aclk);
    if (i == 200) hang();
    chk(w, w0, blk_w0);
    chk("block address", a, blk_addr);
  endtask
  task automatic finish_cmd(input logic eok);
    int i;
    pulse(CEND);
    for (i = 0; i < 8 && next_valid !== 1'b1; i++) @(posedge aclk);
    if (i == 8) hang();
    chk("next command allowed", 32'(eok), 32'(next_ok));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(A_PTR, 32'h0000_0000, 2'b00, "pointer reset");
    rd(A_LEN, 32'h0000_0000, 2'b00, "length reset");
    wr(A_PTR, 32'h0000_1000, 2'b00);
    wr(A_LEN, 32'hFFFF_0024, 2'b00);
    wr(A_STAT, 32'h0000_0000, 2'b10);
    wr(5'h18, 32'h0000_0001, 2'b10);
    rd(A_PTR, 32'h0000_1000, 2'b00, "pointer");
    rd(A_LEN, 32'h0000_0024, 2'b00, "length width");
    rd(5'h18, 32'h0000_0000, 2'b10, "unmapped read");
    wr(A_CTRL, 32'h0000_0001, 2'b00);
  endtask
  task automatic t_ecc();
    want_track <= 16'h0123;
    retry_cnt <= 8'h05;
    start(`CMD_READ, 4'h0, 16'h00A5);
    // A fatal event while the enable is low must leave no block behind
    ce <= 1'b0;
    pulse(VEC);
    ce <= 1'b1;
    pulse(ECC);
    blk("ecc block", {`C_ECC, 8'h05, 16'h00A5}, 32'h0000_1000);
    chk("ecc track", 32'h0000_0123, {16'h0000, blk_w1[15:0]});
    finish_cmd(1'b0);
  endtask
  task automatic t_verify();
    // A stalling memory must not shift or tear the blocks
    stall <= 1'b1;
    retry_cnt <= 8'h02;
    start(`CMD_VERIFY, 4'h1, 16'h0B0B);
    pulse(RETRY);
    blk("retry block", {`C_RETRY, 8'h02, 16'h0B0B}, 32'h0000_100C);
    pulse(ECC);
    pulse(CMP);
    blk("compare block", {`C_NOVERIFY, 8'h00, 16'h0B0B}, 32'h0000_1018);
    pulse(RETRY);
    rd(A_STAT, 32'h0103_0024, 2'b00, "status after full area");
    finish_cmd(1'b1);
    stall <= 1'b0;
  endtask
  task automatic t_fatal();
    wr(A_CTRL, 32'h0000_0003, 2'b00);
    rd(A_CTRL, 32'h0000_0001, 2'b00, "rewind reads back 0");
    start(`CMD_WRITE, 4'h2, 16'h0606);
    pulse(VEC);
    @(posedge aclk);
    chk("abort on fatal", 32'h0000_0001, 32'(cmd_abort));
    chk("no head move", 32'h0000_0000, 32'(vector_req));
    blk("no vector block", {`C_NO_VEC, 8'h00, 16'h0606}, 32'h0000_1000);
    auto_vector <= 1'b1;
    reloc_track <= 16'h0042;
    pulse(RELOC);
    @(posedge aclk);
    chk("head move", 32'h0000_0001, 32'(vector_req));
    chk("reloc keeps going", 32'h0000_0000, 32'(cmd_abort));
    blk("reloc block", {`C_RELOC, 8'h00, 16'h0606}, 32'h0000_100C);
    chk("reloc tracks", 32'h0042_0000, blk_w1);
    auto_vector <= 1'b0;
    finish_cmd(1'b1);
  endtask
  task automatic t_seek();
    wr(A_CTRL, 32'h0000_0003, 2'b00);
    want_track <= 16'h0005;
    hdr_track <= 16'h0007;
    start(`CMD_READ, 4'h1, 16'h0202);
    pulse(HOK);
    @(posedge aclk);
    chk("restore request", 32'h0000_0001, 32'(restore_req));
    blk("seek block", {`C_SEEK, 8'h00, 16'h0202}, 32'h0000_1000);
    chk("seek tracks", 32'h0005_0007, blk_w1);
    pulse(HOK);
    @(posedge aclk);
    chk("fatal seek abort", 32'h0000_0001, 32'(cmd_abort));
    blk("fatal seek block", {`C_FSEEK, 8'h00, 16'h0202}, 32'h0000_100C);
    finish_cmd(1'b0);
  endtask
  task automatic t_search();
    logic [7:0] code [3] = '{`C_NO_ID, `C_RNF_ID, `C_RNF};
    int v;
    wr(A_CTRL, 32'h0000_0003, 2'b00);
    for (v = 0; v < 3; v++) begin
      start(`CMD_READ, 4'h0, 16'h0700 + 16'(v));
      address_mark_found <= (v != 0);
      sect_search <= 1'b1;
      if (v == 1) pulse(HBAD);
      repeat (3) begin
        @(posedge aclk);
        index_pin <= 1'b1;
        repeat (4) @(posedge aclk);
        index_pin <= 1'b0;
        repeat (4) @(posedge aclk);
      end
      blk("search block", {code[v], 8'h00, 16'h0700 + 16'(v)}, 32'h0000_1000 + 12*v);
      sect_search <= 1'b0;
      address_mark_found <= 1'b0;
      finish_cmd(1'b0);
    end
    // Empty window: no data mark before the count runs out ends the command
    start(`CMD_READ, 4'h0, 16'h0800);
    pulse(WIN);
    repeat (2) @(posedge aclk);
    chk("window timeout abort", 32'h0000_0001, 32'(cmd_abort));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_ecc();
    t_verify();
    t_fatal();
    t_seek();
    t_search();
    summarize();
  end
endmodule // disk_error_status_reporter_bench
